// ### rtl/keyboard_mouse_wake_isolation.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
module keyboard_mouse_wake_isolation
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  output logic [3:0] line_oe,
  output logic [3:0] ctrl_line_in,
  input wire logic [3:0] ctrl_drive_low,
  input wire logic ctrl_key_irq,
  input wire logic ctrl_mouse_irq,
  input wire logic host_power_down_n,
  input wire logic system_reset_n,
  input wire logic main_power_good,
  output logic ctrl_reset,
  output logic wake_event_out_n
);

  // Synchronised pins
  logic [wake_iso_pkg::SYNC_WIDTH-1:0] pin_raw;
  logic [wake_iso_pkg::SYNC_WIDTH-1:0] pin_sync;
  logic [3:0] line_sync_v;
  logic power_down;
  logic sys_rst_active;
  logic main_pwr;

  // Register state
  logic [7:0] gate_cfg_ff;
  logic [7:0] nxt_gate_cfg;
  logic [7:0] rst_cfg_ff;
  logic [7:0] nxt_rst_cfg;
  logic [7:0] wake_en_ff;
  logic [7:0] nxt_wake_en;
  logic global_wake_enable_ff;
  logic nxt_global_wake_enable;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Wake detection state
  logic key_data_prev_ff;
  logic mouse_data_prev_ff;
  logic nxt_key_data_prev;
  logic nxt_mouse_data_prev;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic [7:0] status;

  // Isolation and outputs
  logic iso_mode;
  logic key_in_block;
  logic mouse_in_block;
  logic key_drive_block;
  logic mouse_drive_block;
  logic [3:0] in_block;
  logic [3:0] drive_block;
  logic [3:0] ctrl_line_in_ff;
  logic [3:0] nxt_ctrl_line_in;
  logic [3:0] line_oe_ff;
  logic [3:0] nxt_line_oe;
  logic [3:0] line_out_ff;
  logic [3:0] nxt_line_out;
  logic ctrl_reset_ff;
  logic nxt_ctrl_reset;
  logic wake_n_ff;
  logic nxt_wake_n;

  // All pins come from outside the clock domain
  assign pin_raw = {main_power_good, system_reset_n, host_power_down_n,
                    line_in};

  line_sync
  #(
    .WIDTH(wake_iso_pkg::SYNC_WIDTH),
    .RST_VAL(wake_iso_pkg::SYNC_RST)
  )
  u_pin_sync
  (
    .clk(clk),
    .nrst(nrst),
    .din(pin_raw),
    .dout(pin_sync)
  );

  assign line_sync_v = pin_sync[3:0];
  assign power_down = ~pin_sync[wake_iso_pkg::SYNC_PD_N];
  assign sys_rst_active = ~pin_sync[wake_iso_pkg::SYNC_SYS_RST_N];
  assign main_pwr = pin_sync[wake_iso_pkg::SYNC_MAIN_PWR];

  // Isolation decode
  always_comb
  begin
    iso_mode = gate_cfg_ff[wake_iso_pkg::BIT_ISO_MODE];
    // Only the power-down input marks deep sleep, so light sleep is
    // left alone by the hardware term
    key_in_block = gate_cfg_ff[wake_iso_pkg::BIT_KEY_ISO] | power_down;
    mouse_in_block = gate_cfg_ff[wake_iso_pkg::BIT_MOUSE_ISO] | power_down;
    key_drive_block = gate_cfg_ff[wake_iso_pkg::BIT_KEY_ISO] |
                      (~iso_mode & power_down);
    mouse_drive_block = gate_cfg_ff[wake_iso_pkg::BIT_MOUSE_ISO] |
                        (~iso_mode & power_down);
    in_block = '0;
    in_block[wake_iso_pkg::LINE_KEY_CLK] = key_in_block;
    in_block[wake_iso_pkg::LINE_KEY_DAT] = key_in_block;
    in_block[wake_iso_pkg::LINE_MOUSE_CLK] = mouse_in_block;
    in_block[wake_iso_pkg::LINE_MOUSE_DAT] = mouse_in_block;
    drive_block = '0;
    drive_block[wake_iso_pkg::LINE_KEY_CLK] = key_drive_block;
    drive_block[wake_iso_pkg::LINE_KEY_DAT] = key_drive_block;
    drive_block[wake_iso_pkg::LINE_MOUSE_CLK] = mouse_drive_block;
    drive_block[wake_iso_pkg::LINE_MOUSE_DAT] = mouse_drive_block;
  end

  // Line gating toward the controller and toward the pins
  always_comb
  begin
    // Blocked lines look idle high to the controller
    nxt_ctrl_line_in = (line_sync_v & ~in_block) |
                       (wake_iso_pkg::LINES_IDLE & in_block);
    // Controller in reset never pulls a line
    nxt_line_oe = ctrl_drive_low & ~drive_block & {4{~ctrl_reset_ff}};
    nxt_line_out = '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_line_in_ff <= wake_iso_pkg::LINES_IDLE;
      line_oe_ff <= '0;
      line_out_ff <= '0;
    end
    else
    begin
      ctrl_line_in_ff <= nxt_ctrl_line_in;
      line_oe_ff <= nxt_line_oe;
      line_out_ff <= nxt_line_out;
    end
  end

  // Wake event detection
  always_comb
  begin
    nxt_key_data_prev = line_sync_v[wake_iso_pkg::LINE_KEY_DAT];
    nxt_mouse_data_prev = line_sync_v[wake_iso_pkg::LINE_MOUSE_DAT];
    status_set = '0;
    // Interrupt events need main power and an open path, so isolation
    // stops only the controller's own activity
    status_set[wake_iso_pkg::BIT_WAKE_KEY_IRQ] =
      ctrl_key_irq & main_pwr & ~key_drive_block;
    status_set[wake_iso_pkg::BIT_WAKE_MOUSE_IRQ] =
      ctrl_mouse_irq & main_pwr & ~mouse_drive_block;
    // Data lines are taken before any gating, on either supply
    status_set[wake_iso_pkg::BIT_WAKE_KEY_DATA] = key_data_prev_ff &
      ~line_sync_v[wake_iso_pkg::LINE_KEY_DAT];
    status_set[wake_iso_pkg::BIT_WAKE_MOUSE_DATA] = mouse_data_prev_ff &
      ~line_sync_v[wake_iso_pkg::LINE_MOUSE_DAT];
    status_clr = '0;
    if (wr_en && addr == wake_iso_pkg::OFS_WAKE_STATUS)
    begin
      status_clr = wdata & wake_iso_pkg::WAKE_BITS_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      key_data_prev_ff <= 1'b1;
      mouse_data_prev_ff <= 1'b1;
    end
    else
    begin
      key_data_prev_ff <= nxt_key_data_prev;
      mouse_data_prev_ff <= nxt_mouse_data_prev;
    end
  end

  wake_flags
  #(
    .WIDTH(8)
  )
  u_status
  (
    .clk(clk),
    .nrst(nrst),
    .set(status_set),
    .clr(status_clr),
    .q(status)
  );

  // Register writes; nrst is the standby-supply power-on reset
  always_comb
  begin
    nxt_gate_cfg = gate_cfg_ff;
    nxt_rst_cfg = rst_cfg_ff;
    nxt_wake_en = wake_en_ff;
    nxt_global_wake_enable = global_wake_enable_ff;
    // System reset clears main-supply bits only
    if (sys_rst_active)
    begin
      nxt_gate_cfg = gate_cfg_ff & ~wake_iso_pkg::GATE_CFG_MAIN_MASK;
      nxt_rst_cfg = wake_iso_pkg::GLOBAL_RST_CFG_RST;
    end
    else if (wr_en)
    begin
      if (addr == wake_iso_pkg::OFS_KEY_GATE_CFG)
      begin
        nxt_gate_cfg = wdata;
      end
      else if (addr == wake_iso_pkg::OFS_GLOBAL_RST_CFG)
      begin
        nxt_rst_cfg = wdata;
      end
    end
    // Enables live on the standby supply; system reset leaves them
    if (wr_en && addr == wake_iso_pkg::OFS_WAKE_ENABLE)
    begin
      nxt_wake_en = wdata & wake_iso_pkg::WAKE_BITS_MASK;
    end
    else if (wr_en && addr == wake_iso_pkg::OFS_GLOBAL_WAKE)
    begin
      nxt_global_wake_enable = wdata[wake_iso_pkg::BIT_GLOBAL_EN];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    nxt_rdata = wake_iso_pkg::RDATA_RST;
    if (rd_en)
    begin
      if (addr == wake_iso_pkg::OFS_KEY_GATE_CFG)
      begin
        nxt_rdata = gate_cfg_ff;
      end
      else if (addr == wake_iso_pkg::OFS_GLOBAL_RST_CFG)
      begin
        nxt_rdata = rst_cfg_ff;
      end
      else if (addr == wake_iso_pkg::OFS_WAKE_STATUS)
      begin
        nxt_rdata = status;
      end
      else if (addr == wake_iso_pkg::OFS_WAKE_ENABLE)
      begin
        nxt_rdata = wake_en_ff;
      end
      else if (addr == wake_iso_pkg::OFS_GLOBAL_WAKE)
      begin
        nxt_rdata[wake_iso_pkg::BIT_GLOBAL_EN] = global_wake_enable_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gate_cfg_ff <= wake_iso_pkg::GATE_CFG_RST;
      rst_cfg_ff <= wake_iso_pkg::GLOBAL_RST_CFG_RST;
      wake_en_ff <= wake_iso_pkg::WAKE_ENABLE_RST;
      global_wake_enable_ff <= 1'b0;
      rdata_ff <= wake_iso_pkg::RDATA_RST;
    end
    else
    begin
      gate_cfg_ff <= nxt_gate_cfg;
      rst_cfg_ff <= nxt_rst_cfg;
      wake_en_ff <= nxt_wake_en;
      global_wake_enable_ff <= nxt_global_wake_enable;
      rdata_ff <= nxt_rdata;
    end
  end

  // Controller reset and wake event output
  always_comb
  begin
    // Power-down leaves before system reset does, so hardware isolation
    // is already gone when the controller starts
    nxt_ctrl_reset = rst_cfg_ff[wake_iso_pkg::BIT_CTRL_RST] |
                     sys_rst_active;
    nxt_wake_n = ~(global_wake_enable_ff &
                   (|(status & wake_en_ff)));
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reset_ff <= 1'b1;
      wake_n_ff <= 1'b1;
    end
    else
    begin
      ctrl_reset_ff <= nxt_ctrl_reset;
      wake_n_ff <= nxt_wake_n;
    end
  end

  assign rdata = rdata_ff;
  assign line_out = line_out_ff;
  assign line_oe = line_oe_ff;
  assign ctrl_line_in = ctrl_line_in_ff;
  assign ctrl_reset = ctrl_reset_ff;
  assign wake_event_out_n = wake_n_ff;

endmodule : keyboard_mouse_wake_isolation

// ### rtl/wake_iso_pkg.sv
package wake_iso_pkg;

  // Register offsets
  localparam logic [7:0] OFS_KEY_GATE_CFG = 8'hF0;
  localparam logic [7:0] OFS_GLOBAL_RST_CFG = 8'h2C;
  localparam logic [7:0] OFS_WAKE_STATUS = 8'h40;
  localparam logic [7:0] OFS_WAKE_ENABLE = 8'h41;
  localparam logic [7:0] OFS_GLOBAL_WAKE = 8'h42;

  // Fields of keyboard_reset_gate_config
  localparam int BIT_ISO_MODE = 7;
  localparam int BIT_MOUSE_ISO = 6;
  localparam int BIT_KEY_ISO = 5;
  // Bits cleared by a system reset; only the key and mouse isolation bits are standby-kept
  localparam logic [7:0] GATE_CFG_MAIN_MASK = 8'h9F;

  // Field of global_controller_reset_config
  localparam int BIT_CTRL_RST = 6;

  // Wake status and enable layout
  localparam int BIT_WAKE_KEY_IRQ = 0;
  localparam int BIT_WAKE_MOUSE_IRQ = 1;
  localparam int BIT_WAKE_KEY_DATA = 3;
  localparam int BIT_WAKE_MOUSE_DATA = 4;
  localparam logic [7:0] WAKE_BITS_MASK = 8'h1B;

  // Global enable field
  localparam int BIT_GLOBAL_EN = 0;

  // Reset values
  localparam logic [7:0] GATE_CFG_RST = 8'h00;
  localparam logic [7:0] GLOBAL_RST_CFG_RST = 8'h00;
  localparam logic [7:0] WAKE_ENABLE_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Serial line indices
  localparam int NUM_LINES = 4;
  localparam int LINE_KEY_CLK = 0;
  localparam int LINE_KEY_DAT = 1;
  localparam int LINE_MOUSE_CLK = 2;
  localparam int LINE_MOUSE_DAT = 3;
  localparam logic [3:0] LINES_IDLE = 4'hF;

  // Pin synchroniser layout: lines, power-down, system reset, main power
  localparam int SYNC_WIDTH = 7;
  localparam int SYNC_PD_N = 4;
  localparam int SYNC_SYS_RST_N = 5;
  localparam int SYNC_MAIN_PWR = 6;
  localparam logic [6:0] SYNC_RST = 7'h3F;

endpackage : wake_iso_pkg

// ### rtl/line_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change is taken once stages two and
// three agree, which also rejects a single-sample glitch
module line_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] dout_ff;
  logic [WIDTH-1:0] nxt_dout;

  // Hold the last agreed value while stages two and three differ
  always_comb
  begin
    nxt_dout = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & dout_ff);
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout_ff <= nxt_dout;
    end
  end

  assign dout = dout_ff;

endmodule : line_sync

// ### rtl/wake_flags.sv
`timescale 1ns/1ps
// Sticky event flags; a set in the same cycle as a clear wins
module wake_flags
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] flag_ff;
  logic [WIDTH-1:0] nxt_flag;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_flag
      // Set has priority so no event is lost during a clear
      always_comb
      begin
        nxt_flag[i] = set[i] | (flag_ff[i] & ~clr[i]);
      end

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          flag_ff[i] <= 1'b0;
        end
        else
        begin
          flag_ff[i] <= nxt_flag[i];
        end
      end
    end
  endgenerate

  assign q = flag_ff;

endmodule : wake_flags

// ### testbench/kbd_wake_asserts.sv
`timescale 1ns/1ps
// Port checks; shadows of written bits stand in for hidden registers
module kbd_wake_asserts
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [3:0] line_in,
  input wire logic [3:0] line_oe,
  input wire logic [3:0] ctrl_line_in,
  input wire logic host_power_down_n,
  input wire logic system_reset_n,
  input wire logic ctrl_reset,
  input wire logic wake_event_out_n
);
  logic [1:0] iso_ff, nxt_iso;
  logic [7:0] en_ff, nxt_en;
  logic glob_ff, nxt_glob, rst_ff, nxt_rst;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Reset bit shadow drops early on system reset, so it never overclaims
  always_comb
  begin
    nxt_iso = iso_ff;
    nxt_en = en_ff;
    nxt_glob = glob_ff;
    nxt_rst = rst_ff && system_reset_n;
    if (wr_en && addr == wake_iso_pkg::OFS_KEY_GATE_CFG)
      nxt_iso = wdata[6:5];
    if (wr_en && addr == wake_iso_pkg::OFS_WAKE_ENABLE)
      nxt_en = wdata & wake_iso_pkg::WAKE_BITS_MASK;
    if (wr_en && addr == wake_iso_pkg::OFS_GLOBAL_WAKE)
      nxt_glob = wdata[wake_iso_pkg::BIT_GLOBAL_EN];
    if (wr_en && system_reset_n && addr == wake_iso_pkg::OFS_GLOBAL_RST_CFG)
      nxt_rst = wdata[wake_iso_pkg::BIT_CTRL_RST];
  end
  // Shadow registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      {iso_ff, en_ff, glob_ff, rst_ff} <= '0;
    else
      {iso_ff, en_ff, glob_ff, rst_ff} <= {nxt_iso, nxt_en, nxt_glob, nxt_rst};
  end
  // Key data fall held long enough to pass the glitch filter
  sequence key_fall_s;
    $fell(line_in[1]) ##1 !line_in[1] [*3];
  endsequence
  sequence key_armed_s;
    glob_ff && en_ff[wake_iso_pkg::BIT_WAKE_KEY_DATA];
  endsequence
  a_key_data_wake: assert property (
    key_armed_s ##0 key_fall_s |-> ##[1:4] !wake_event_out_n)
    else $error("key data fall gave no wake event");
  a_wake_needs_en: assert property (
    !wake_event_out_n |-> $past(glob_ff) && $past(en_ff) != 8'h00)
    else $error("wake event without enables");
  a_key_iso_block: assert property (iso_ff[0] |=>
    ctrl_line_in[1:0] == 2'h3 && line_oe[1:0] == 2'h0)
    else $error("keyboard lines pass while isolated");
  a_mouse_iso_block: assert property (iso_ff[1] |=>
    ctrl_line_in[3:2] == 2'h3 && line_oe[3:2] == 2'h0)
    else $error("mouse lines pass while isolated");
  a_pd_input_block: assert property (
    !host_power_down_n [*8] |-> ctrl_line_in == 4'hF)
    else $error("input path open during power-down");
  a_sysrst_holds: assert property (
    !system_reset_n [*8] |-> ctrl_reset)
    else $error("controller out of reset during system reset");
  a_ctrl_rst_bit: assert property (rst_ff |=> ctrl_reset)
    else $error("controller reset bit not honoured");
  a_rdata_one_cycle: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : kbd_wake_asserts

bind keyboard_mouse_wake_isolation kbd_wake_asserts u_kbd_wake_asserts
(
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .line_in(line_in), .line_oe(line_oe),
  .ctrl_line_in(ctrl_line_in), .host_power_down_n(host_power_down_n),
  .system_reset_n(system_reset_n), .ctrl_reset(ctrl_reset),
  .wake_event_out_n(wake_event_out_n)
);

// ### testbench/serial_peer.sv
`timescale 1ns/1ps
// Far-side keyboard or mouse; its clock runs only inside a frame
module serial_peer
(
  input wire logic go,
  input wire logic sel,
  input wire logic [7:0] byte_in,
  output logic busy,
  output logic [3:0] pull_low
);
  logic [10:0] frame;
  initial
  begin
    busy = 1'h0;
    pull_low = 4'h0;
  end
  // Start, data LSB first, odd parity, stop; offset keeps off clk edges
  always @(posedge go)
  begin
    busy = 1'h1;
    frame = {1'h1, ~^byte_in, byte_in, 1'h0};
    #7;
    for (int i = 0; i < 11; i++)
    begin
      pull_low[{sel, 1'h1}] = ~frame[i];
      #40 pull_low[{sel, 1'h0}] = 1'h1;
      #80 pull_low[{sel, 1'h0}] = 1'h0;
      #40;
    end
    pull_low = 4'h0;
    busy = 1'h0;
  end
endmodule : serial_peer

// ### testbench/keyboard_mouse_wake_isolation_bench.sv
`timescale 1ns/1ps
// Bench for the wake and isolation block with a far-side peer
module keyboard_mouse_wake_isolation_bench;
  logic clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, byte_in = 8'h00;
  logic [3:0] ctrl_drive_low = 4'h0;
  logic ctrl_key_irq = 1'h0, ctrl_mouse_irq = 1'h0, go = 1'h0, sel = 1'h0;
  logic host_power_down_n = 1'h1, system_reset_n = 1'h1;
  logic main_power_good = 1'h0;
  logic [7:0] rdata, v;
  logic [3:0] line_in, line_out, line_oe, ctrl_line_in, pull_low;
  logic ctrl_reset, wake_event_out_n, busy;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 55266;
  always #5 clk = ~clk;
  // Pull-ups on every line; any party pulling low wins
  assign line_in = ~(line_oe | pull_low);
  keyboard_mouse_wake_isolation u_keyboard_mouse_wake_isolation
  (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .ctrl_line_in(ctrl_line_in),
    .ctrl_drive_low(ctrl_drive_low), .ctrl_key_irq(ctrl_key_irq),
    .ctrl_mouse_irq(ctrl_mouse_irq), .host_power_down_n(host_power_down_n),
    .system_reset_n(system_reset_n), .main_power_good(main_power_good),
    .ctrl_reset(ctrl_reset), .wake_event_out_n(wake_event_out_n)
  );
  serial_peer u_serial_peer
  (
    .go(go), .sel(sel), .byte_in(byte_in), .busy(busy), .pull_low(pull_low)
  );
  // Expected read-backs
  function automatic logic [7:0] en_exp(input logic [7:0] d);
    return d & wake_iso_pkg::WAKE_BITS_MASK;
  endfunction : en_exp
  function automatic logic [7:0] gate_exp(input logic [7:0] d);
    return d & ~wake_iso_pkg::GATE_CFG_MAIN_MASK;
  endfunction : gate_exp
  task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check_eq
  // Bus cycles, strobes one cycle long
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 check_eq(rdata, e);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks
  // Pin paths need sync time before they settle
  task automatic pins(input logic [7:0] e);
    ticks(8);
    #1 check_eq({line_oe, ctrl_line_in}, e);
    check_eq(8'(line_out), 8'h00);
  endtask : pins
  task automatic pulse_irq(input logic k, input logic m);
    @(posedge clk);
    ctrl_key_irq <= k;
    ctrl_mouse_irq <= m;
    ticks(3);
    ctrl_key_irq <= 1'h0;
    ctrl_mouse_irq <= 1'h0;
  endtask : pulse_irq
  task automatic send(input logic s);
    @(posedge clk);
    sel <= s;
    byte_in <= 8'($random(seed));
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    for (int i = 0; i < 400 && busy === 1'h1; i++) @(posedge clk);
    // A frame that never ends is a mismatch, not a silent pass
    check_eq(8'(busy), 8'h00);
    ticks(8);
  endtask : send
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Whole run is near 620 cycles; over thirty times that means a hang
  initial
  begin
    #200000;
    bad_count++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    rd(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h00);
    rd(wake_iso_pkg::OFS_GLOBAL_RST_CFG, 8'h00);
    rd(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h00);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h00);
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    repeat (4)
    begin
      v = 8'($random(seed));
      wr(wake_iso_pkg::OFS_WAKE_ENABLE, v);
      rd(wake_iso_pkg::OFS_WAKE_ENABLE, en_exp(v));
      wr(wake_iso_pkg::OFS_KEY_GATE_CFG, v);
      rd(wake_iso_pkg::OFS_KEY_GATE_CFG, v);
    end
    wr(wake_iso_pkg::OFS_GLOBAL_RST_CFG, 8'h40);
    ticks(30);
    #1 check_eq(8'(ctrl_reset), 8'h01);
    wr(wake_iso_pkg::OFS_GLOBAL_RST_CFG, 8'h00);
    ticks(2);
    #1 check_eq(8'(ctrl_reset), 8'h00);
    $display("Test registers done");
    // Data wake on standby supply, keyboard isolated meanwhile
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h20);
    wr(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h08);
    wr(wake_iso_pkg::OFS_GLOBAL_WAKE, 8'h01);
    send(1'h0);
    #1 check_eq(8'(wake_event_out_n), 8'h00);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h08);
    wr(wake_iso_pkg::OFS_WAKE_STATUS, 8'hFF);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h00);
    send(1'h1);
    #1 check_eq(8'(wake_event_out_n), 8'h01);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h10);
    wr(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h10);
    ticks(2);
    #1 check_eq(8'(wake_event_out_n), 8'h00);
    wr(wake_iso_pkg::OFS_GLOBAL_WAKE, 8'h00);
    ticks(2);
    #1 check_eq(8'(wake_event_out_n), 8'h01);
    wr(wake_iso_pkg::OFS_WAKE_STATUS, 8'hFF);
    $display("Test data wake done");
    // Interrupt wake needs main supply; isolation stops controller source
    pulse_irq(1'h1, 1'h1);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h00);
    @(posedge clk) main_power_good <= 1'h1;
    ticks(6);
    pulse_irq(1'h1, 1'h1);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h02);
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h00);
    pulse_irq(1'h1, 1'h0);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h03);
    wr(wake_iso_pkg::OFS_WAKE_STATUS, 8'h01);
    rd(wake_iso_pkg::OFS_WAKE_STATUS, 8'h02);
    wr(wake_iso_pkg::OFS_WAKE_STATUS, 8'hFF);
    $display("Test interrupt wake done");
    // Isolation modes with the controller pulling both clocks low
    @(posedge clk) ctrl_drive_low <= 4'h5;
    pins(8'h5A);
    @(posedge clk) host_power_down_n <= 1'h0;
    pins(8'h0F);
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h80);
    pins(8'h5F);
    @(posedge clk) host_power_down_n <= 1'h1;
    pins(8'h5A);
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'hC0);
    pins(8'h1E);
    // Main supply stayed up: clearing the bits alone reopens the lines
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h00);
    pins(8'h5A);
    @(posedge clk) ctrl_drive_low <= 4'h0;
    $display("Test isolation done");
    // System reset keeps standby bits; standby reset clears them
    v = 8'($random(seed));
    wr(wake_iso_pkg::OFS_KEY_GATE_CFG, v);
    wr(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h1B);
    @(posedge clk) system_reset_n <= 1'h0;
    ticks(10);
    #1 check_eq(8'(ctrl_reset), 8'h01);
    @(posedge clk) system_reset_n <= 1'h1;
    ticks(10);
    #1 check_eq(8'(ctrl_reset), 8'h00);
    rd(wake_iso_pkg::OFS_KEY_GATE_CFG, gate_exp(v));
    rd(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h1B);
    @(posedge clk) nrst <= 1'h0;
    ticks(2);
    nrst <= 1'h1;
    rd(wake_iso_pkg::OFS_KEY_GATE_CFG, 8'h00);
    rd(wake_iso_pkg::OFS_WAKE_ENABLE, 8'h00);
    $display("Test resets done");
    give_verdict();
  end
endmodule : keyboard_mouse_wake_isolation_bench
